/* core/cpu_port_pkg.sv */
// Summary of operation
// - indexed mode: address cycle with address_select low, next data cycle uses it.
// - an access ends when its read or write strobe or chip select goes inactive, whichever first.
// - multiplexed mode latches the location from the data lines while latch strobe high.
// - multiplexed data cycle is chip select plus read or write strobe on latched location.
// - eight-bit two-way data path, driven by the device only while reading.
// - 256-byte memory, lowest 16 are registers, the remaining 240 are data buffer.
// - USB data goes into the buffer at software pointer and length positions.
// - exactly one interrupt output, set by several USB events.
// - software enables any event combination and can read which events are pending.
// - writing ones to the interrupt status register at 0x0d clears those pending interrupts.
// - role pin low selects host role, left open selects peripheral role.
// - runs from a 48 MHz source, crystal or external clock; here clk_sys is taken as 100 MHz (CLK_MHZ).
// - host data transfers are sustained above 10 megabytes per second.
// - only full-speed 12 megabit signalling, in both roles.
// - each data cycle advances the location pointer by one.
// - interrupt enable at location 06h, interrupt status at location 0dh.
package cpu_port_pkg;
	localparam int unsigned MEM_DEPTH   = 256;
	localparam int unsigned REG_COUNT   = 16;
	localparam logic [7:0]  BASE_ADDR   = 8'h01;
	localparam logic [7:0]  BASE_LEN    = 8'h02;
	localparam logic [7:0]  XFER_COUNT  = 8'h04;
	localparam logic [7:0]  IRQ_ENABLE  = 8'h06;
	localparam logic [7:0]  IRQ_STATUS  = 8'h0D;
	localparam logic [7:0]  ROLE_STATUS = 8'h0E;
	localparam logic [7:0]  BUF_FIRST   = 8'h10;
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [13:0] PIN_IDLE    = 14'h3C00; // strobes and select high, latch and mux low, bus zero
	localparam logic [7:0]  ONE_BYTE    = 8'h01;
	localparam int unsigned ROLE_BIT    = 0;
	localparam int unsigned CLK_MHZ     = 100;
	localparam int unsigned HOST_RATE_MBPS = 10;
	// least bytes of host traffic per microsecond, as cycles per byte at clk_sys
	localparam int unsigned CYCLES_PER_BYTE = CLK_MHZ / HOST_RATE_MBPS;
endpackage

/* core/cpu_port_indexed_buffer_access.sv */
module cpu_port_indexed_buffer_access (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       chip_select_n,
	input  wire logic       write_strobe_n,
	input  wire logic       readStrobeN,
	input  wire logic       address_select,
	input  wire logic       addrLatch,
	input  wire logic       muxMode,
	input  wire logic [7:0] dataIn,
	output logic      [7:0] dataOut,
	output logic            dataOe,
	output logic            irq_out,
	input  wire logic       rolePinN,
	output logic            hostRole,
	input  wire logic       usbWrValid,
	input  wire logic [7:0] usbWrData,
	input  wire logic       usbRdReq,
	output logic      [7:0] usbRdData,
	output logic            usbRdValid,
	output logic            usbDone,
	input  wire logic [7:0] usbEvents
);
	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops before any logic
	logic [13:0] pinMeta;
	logic [13:0] pinSync;
	logic        csN, wrN, rdN, aSel, ale, mux, roleN;
	logic [7:0]  busData;

	// reset to idle pin levels, so no false latch or strobe edge follows reset
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pinMeta <= cpu_port_pkg::PIN_IDLE;
			pinSync <= cpu_port_pkg::PIN_IDLE;
		end else begin
			pinMeta <= {chip_select_n, write_strobe_n, readStrobeN, address_select,
				addrLatch, muxMode, dataIn};
			pinSync <= pinMeta;
		end
	end
	assign {csN, wrN, rdN, aSel, ale, mux, busData} = pinSync;

	logic roleMeta;
	logic roleSync;
	// role pin has a pull-up in the pad, so open reads high
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			roleMeta <= 1'b1;
			roleSync <= 1'b1;
		end else begin
			roleMeta <= rolePinN;
			roleSync <= roleMeta;
		end
	end
	assign roleN = roleSync;

	////////////////////////////////////////////////////////////////////////////////
	// access framing: one action per strobe, ended by whichever of strobe or select lifts
	logic wrActive, rdActive, wrPrev, rdPrev, aleWasHigh;
	logic wrStart, rdStart;
	assign wrActive = !csN && !wrN;
	assign rdActive = !csN && !rdN;
	// three low and three high cycles per strobe are enough, well above 10 MB/s
	assign wrStart  = wrActive && !wrPrev;
	assign rdStart  = rdActive && !rdPrev;

	// last synced strobe state, so a long strobe acts only once
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			wrPrev <= 1'b0;
			rdPrev <= 1'b0;
		end else begin
			wrPrev <= wrActive;
			rdPrev <= rdActive;
		end
	end

	// in multiplexed mode address_select is ignored, each data cycle is a data access
	logic dataCycle;
	assign dataCycle = mux ? 1'b1 : aSel;

	////////////////////////////////////////////////////////////////////////////////
	// location pointer
	logic [7:0] ptr_reg;
	logic       ptrBump;
	assign ptrBump = (wrStart || rdStart) && dataCycle;

	// latch strobe first, then address cycle, then data-cycle step; wraps at the top
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ptr_reg <= cpu_port_pkg::RESET_BYTE;
		end else if (mux && ale) begin
			ptr_reg <= busData;
		end else if (wrStart && !dataCycle) begin
			ptr_reg <= busData;
		end else if (ptrBump) begin
			ptr_reg <= ptr_reg + cpu_port_pkg::ONE_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// memory: low 16 locations registers, rest data buffer
	logic [7:0] mem [0:cpu_port_pkg::MEM_DEPTH-1];
	logic [7:0] irqEn_reg;
	logic [7:0] irqStat_reg;
	logic [7:0] usbPtr_reg;
	logic [7:0] usbLeft_reg;
	logic       hostWr;
	assign hostWr = wrStart && dataCycle;

	function automatic logic isBuffer(input logic [7:0] a);
		isBuffer = (a >= cpu_port_pkg::BUF_FIRST);
	endfunction

	// single write port; host data cycles win over usb traffic in the same cycle
	always_ff @(posedge clk_sys) begin
		if (hostWr) begin
			mem[ptr_reg] <= busData;
		end else if (usbWrValid && usbLeft_reg != cpu_port_pkg::RESET_BYTE && isBuffer(usbPtr_reg)) begin
			mem[usbPtr_reg] <= usbWrData;
		end
	end

	// usb side streams at the base and length software wrote
	// one byte per request at most; a full-speed engine asks far less often
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			usbPtr_reg  <= cpu_port_pkg::RESET_BYTE;
			usbLeft_reg <= cpu_port_pkg::RESET_BYTE;
			usbDone     <= 1'b0;
		end else begin
			usbDone <= 1'b0;
			if (hostWr && ptr_reg == cpu_port_pkg::BASE_ADDR) begin
				usbPtr_reg <= busData;
			end else if (hostWr && ptr_reg == cpu_port_pkg::BASE_LEN) begin
				usbLeft_reg <= busData;
			end else if ((usbWrValid || usbRdReq) && usbLeft_reg != cpu_port_pkg::RESET_BYTE) begin
				usbPtr_reg  <= usbPtr_reg + cpu_port_pkg::ONE_BYTE;
				usbLeft_reg <= usbLeft_reg - cpu_port_pkg::ONE_BYTE;
				usbDone     <= (usbLeft_reg == cpu_port_pkg::ONE_BYTE);
			end
		end
	end

	// usb read answer stands one cycle after the request
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			usbRdData  <= cpu_port_pkg::RESET_BYTE;
			usbRdValid <= 1'b0;
		end else begin
			usbRdValid <= usbRdReq && usbLeft_reg != cpu_port_pkg::RESET_BYTE;
			usbRdData  <= mem[usbPtr_reg];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt enable and status
	// enable byte, one bit per event source
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irqEn_reg <= cpu_port_pkg::RESET_BYTE;
		end else if (hostWr && ptr_reg == cpu_port_pkg::IRQ_ENABLE) begin
			irqEn_reg <= busData;
		end
	end

	// written ones clear; a new event in the same cycle stays set
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irqStat_reg <= cpu_port_pkg::RESET_BYTE;
		end else if (hostWr && ptr_reg == cpu_port_pkg::IRQ_STATUS) begin
			irqStat_reg <= (irqStat_reg & ~busData) | usbEvents;
		end else begin
			irqStat_reg <= irqStat_reg | usbEvents;
		end
	end

	// registered, so the pin never glitches while status and enables change
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_out <= 1'b0;
		end else begin
			irq_out <= |(irqStat_reg & irqEn_reg);
		end
	end

	// role follows the strap, re-sampled every cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hostRole <= 1'b0;
		end else begin
			hostRole <= !roleN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path; data driven only during read accesses
	logic [7:0] rdByte;
	always_comb begin
		rdByte = mem[ptr_reg];
		case (ptr_reg)
			cpu_port_pkg::IRQ_ENABLE:  rdByte = irqEn_reg;
			cpu_port_pkg::IRQ_STATUS:  rdByte = irqStat_reg;
			cpu_port_pkg::BASE_ADDR:   rdByte = usbPtr_reg;
			cpu_port_pkg::XFER_COUNT:  rdByte = usbLeft_reg;
			cpu_port_pkg::ROLE_STATUS: rdByte = {7'h00, !roleN};
			default:                   rdByte = mem[ptr_reg];
		endcase
	end

	// enable drops a few cycles after the pin lifts, through the sync delay
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dataOut <= cpu_port_pkg::RESET_BYTE;
			dataOe  <= 1'b0;
		end else begin
			dataOe <= rdActive && dataCycle;
			if (rdStart && dataCycle) begin
				dataOut <= rdByte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence addrCycle_s;
		wrStart && !dataCycle && !(mux && ale);
	endsequence

	ptr_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		addrCycle_s |=> ptr_reg == $past(busData))
		else $error("address cycle did not load pointer");
	ptr_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ptrBump && !(mux && ale) |=> ptr_reg == $past(ptr_reg) + cpu_port_pkg::ONE_BYTE)
		else $error("pointer did not advance");
	ale_load_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mux && ale |=> ptr_reg == $past(busData))
		else $error("latch strobe did not load pointer");
	drive_end_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(csN || rdN) |=> !dataOe)
		else $error("data driven after access ended");
	drive_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dataOe |-> $past(rdActive))
		else $error("data driven outside a read");
	irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		|(irqStat_reg & irqEn_reg) |=> irq_out)
		else $error("interrupt not raised");
	irq_quiet_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!(|(irqStat_reg & irqEn_reg)) |=> !irq_out)
		else $error("interrupt raised without cause");
	stat_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		hostWr && ptr_reg == cpu_port_pkg::IRQ_STATUS && usbEvents == cpu_port_pkg::RESET_BYTE
			|=> (irqStat_reg & $past(busData)) == cpu_port_pkg::RESET_BYTE)
		else $error("status write did not clear");
	en_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		hostWr && ptr_reg == cpu_port_pkg::IRQ_ENABLE |=> irqEn_reg == $past(busData))
		else $error("enable write lost");
	role_pin_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!roleN |=> hostRole)
		else $error("role not followed");

	// read answer: start of a data read, then the byte on the pins one cycle later
	sequence rdCycle_s;
		rdStart && dataCycle;
	endsequence
	rd_answer_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rdCycle_s |=> dataOe && dataOut == $past(rdByte))
		else $error("read answer late or wrong");
	out_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		dataOe && !rdStart |=> $stable(dataOut))
		else $error("read byte changed while driven");

	// usb take: a request with bytes left, not overridden by a host base or length write
	sequence usbTake_s;
		(usbWrValid || usbRdReq) && usbLeft_reg != cpu_port_pkg::RESET_BYTE
			&& !(hostWr && (ptr_reg == cpu_port_pkg::BASE_ADDR || ptr_reg == cpu_port_pkg::BASE_LEN));
	endsequence
	usb_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		usbTake_s |=> usbLeft_reg == $past(usbLeft_reg) - cpu_port_pkg::ONE_BYTE)
		else $error("usb length did not count down");
	usb_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		usbDone |-> usbLeft_reg == cpu_port_pkg::RESET_BYTE)
		else $error("done pulse with bytes left");
	usb_guard_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		usbWrValid && !hostWr && !isBuffer(usbPtr_reg) |=> mem[$past(usbPtr_reg)] == $past(mem[usbPtr_reg]))
		else $error("usb data written into register space");

	wr_land_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		hostWr |=> mem[$past(ptr_reg)] == $past(busData))
		else $error("host write did not land");
	wr_once_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wrStart |=> !wrStart)
		else $error("one strobe acted twice");
	stat_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		usbEvents != cpu_port_pkg::RESET_BYTE |=> (irqStat_reg & $past(usbEvents)) == $past(usbEvents))
		else $error("event lost from status");
	ptr_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!ptrBump && !wrStart && !(mux && ale) |=> $stable(ptr_reg))
		else $error("pointer moved without an access");
	role_open_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		roleN |=> !hostRole)
		else $error("peripheral role not followed");
endmodule

/* sim/cpu_bus_model.sv */
module cpu_bus_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] dataOut,
	input  wire logic       dataOe,
	input  wire logic       muxMode,
	output logic            chip_select_n,
	output logic            write_strobe_n,
	output logic            readStrobeN,
	output logic            address_select,
	output logic            addrLatch,
	output logic      [7:0] dataIn,
	output logic      [7:0] rdData,
	output logic            rdSeen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] busDrive;
	logic       busOn;
	logic [7:0] busLast;
	////////////////////////////////////////////////////////////////
	// idle pins, all strobes released
	initial begin
		{chip_select_n, write_strobe_n, readStrobeN, address_select, addrLatch} = 5'h1E;
		{busOn, rdSeen, busDrive, busLast, rdData} = '0;
	end
	// undriven bus toggles every cycle so a stale byte never looks valid
	always @(posedge clk_sys) busLast <= dataIn;
	always_comb dataIn = dataOe ? dataOut : (busOn ? busDrive : ~busLast);
	////////////////////////////////////////////////////////////////
	// one bus cycle, entered at a falling edge; select low 4 cycles, strobe low 5, nine cycles a byte
	task automatic strobe(input logic isRd, input logic isAddr, input logic [7:0] val);
		busDrive = val;
		busOn = ~isRd;
		address_select = muxMode | ~isAddr;
		chip_select_n = 1'b0;
		if (isRd) readStrobeN = 1'b0;
		else write_strobe_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		rdData = dataIn;
		rdSeen = isRd;
		chip_select_n = 1'b1;
		@(negedge clk_sys);
		{rdSeen, busOn, write_strobe_n, readStrobeN} = 4'h3;
		repeat (4) @(negedge clk_sys);
	endtask
	// address phase of the multiplexed bus, bus held past the latch fall
	task automatic latch(input logic [7:0] loc);
		busDrive = loc;
		busOn = 1'b1;
		addrLatch = 1'b1;
		repeat (4) @(negedge clk_sys);
		addrLatch = 1'b0;
		repeat (3) @(negedge clk_sys);
		busOn = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask
endmodule

/* sim/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, sys_rst, muxMode, rolePinN, usbWrValid, usbRdReq, addrLatch;
	logic        chip_select_n, write_strobe_n, readStrobeN, address_select, dataOe, irq_out;
	logic        hostRole, usbRdValid, usbDone, rdSeen;
	logic  [7:0] dataIn, dataOut, usbWrData, usbRdData, usbEvents, rdData, en, ev;
	logic  [7:0] buf8 [8];
	logic  [7:0] expQ [$];
	logic  [7:0] usbQ [$];
	int          mismatches, checked, doneCount;
	time         t0;
	////////////////////////////////////////////////////////////////
	cpu_port_indexed_buffer_access u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .chip_select_n(chip_select_n),
		.write_strobe_n(write_strobe_n), .readStrobeN(readStrobeN), .address_select(address_select),
		.addrLatch(addrLatch), .muxMode(muxMode), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
		.irq_out(irq_out), .rolePinN(rolePinN), .hostRole(hostRole), .usbWrValid(usbWrValid),
		.usbWrData(usbWrData), .usbRdReq(usbRdReq), .usbRdData(usbRdData), .usbRdValid(usbRdValid),
		.usbDone(usbDone), .usbEvents(usbEvents));
	cpu_bus_model u_cpu (.clk_sys(clk_sys), .dataOut(dataOut), .dataOe(dataOe), .muxMode(muxMode),
		.chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .readStrobeN(readStrobeN),
		.address_select(address_select), .addrLatch(addrLatch), .dataIn(dataIn), .rdData(rdData),
		.rdSeen(rdSeen));
	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (mismatches == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// address cycle then one data cycle
	task automatic wr(input logic [7:0] loc, input logic [7:0] val);
		u_cpu.strobe(1'b0, 1'b1, loc);
		u_cpu.strobe(1'b0, 1'b0, val);
	endtask
	task automatic rd(input logic [7:0] loc, input logic [7:0] exp);
		u_cpu.strobe(1'b0, 1'b1, loc);
		expQ.push_back(exp);
		u_cpu.strobe(1'b1, 1'b0, 8'h00);
	endtask
	// results against the oldest note; an empty queue shows up as a mismatch
	always @(posedge clk_sys) begin
		if (rdSeen === 1'b1) check("bus read", rdData, expQ.pop_front());
		if (usbRdValid === 1'b1) check("usb read", usbRdData, usbQ.pop_front());
		if (usbDone === 1'b1) doneCount++;
	end
	// cut a hang short well past the expected run of under a thousand cycles
	initial begin
		#100us;
		mismatches++;
		results();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, rolePinN} = 2'h3;
		{muxMode, usbWrValid, usbRdReq, usbWrData, usbEvents, mismatches, checked, doneCount} = '0;
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		void'($urandom(64190));
		check("reset irq", {7'h00, irq_out}, 8'h00);
		// data cycle with no address cycle lands at location zero
		u_cpu.strobe(1'b0, 1'b0, 8'h5A);
		rd(8'h00, 8'h5A);
		for (int i = 0; i < 8; i++) buf8[i] = 8'($urandom());
		// burst into the buffer, then read it back with one address cycle
		u_cpu.strobe(1'b0, 1'b1, cpu_port_pkg::BUF_FIRST);
		for (int i = 0; i < 8; i++) u_cpu.strobe(1'b0, 1'b0, buf8[i]);
		u_cpu.strobe(1'b0, 1'b1, cpu_port_pkg::BUF_FIRST);
		// back-to-back reads must take under 100 ns per byte
		t0 = $time;
		for (int i = 0; i < 8; i++) begin
			expQ.push_back(buf8[i]);
			u_cpu.strobe(1'b1, 1'b0, 8'h00);
		end
		check("burst rate", {7'h00, ($time - t0) < 8 * cpu_port_pkg::CYCLES_PER_BYTE * 10}, 8'h01);
		// pointer wraps from the top location to zero
		wr(8'hFF, buf8[1]);
		u_cpu.strobe(1'b0, 1'b0, buf8[2]);
		rd(8'hFF, buf8[1]);
		rd(8'h00, buf8[2]);
		// multiplexed bus: latched location, select line held high
		muxMode = 1'b1;
		u_cpu.latch(8'h40);
		u_cpu.strobe(1'b0, 1'b0, buf8[3]);
		u_cpu.latch(8'h40);
		expQ.push_back(buf8[3]);
		u_cpu.strobe(1'b1, 1'b0, 8'h00);
		muxMode = 1'b0;
		@(negedge clk_sys); // let the mode reach the model before its next strobe
		// interrupt enable, pending view and clear
		for (int i = 0; i < 4; i++) begin
			en = (i == 0) ? 8'h00 : 8'($urandom());
			ev = 8'($urandom()) | 8'h01;
			wr(cpu_port_pkg::IRQ_ENABLE, en);
			usbEvents = ev;
			@(negedge clk_sys);
			usbEvents = 8'h00;
			repeat (3) @(negedge clk_sys);
			check("irq set", {7'h00, irq_out}, {7'h00, |(en & ev)});
			rd(cpu_port_pkg::IRQ_ENABLE, en);
			rd(cpu_port_pkg::IRQ_STATUS, ev);
			wr(cpu_port_pkg::IRQ_STATUS, 8'hFF);
			check("irq clear", {7'h00, irq_out}, 8'h00);
			rd(cpu_port_pkg::IRQ_STATUS, 8'h00);
		end
		// role strap, low pin means host
		for (int i = 0; i < 2; i++) begin
			rolePinN = i[0];
			repeat (5) @(negedge clk_sys);
			check("role", {7'h00, hostRole}, {7'h00, ~i[0]});
			rd(cpu_port_pkg::ROLE_STATUS, {7'h00, ~i[0]});
		end
		// engine writes three bytes at the base pointer, then reads two back
		wr(cpu_port_pkg::BASE_ADDR, 8'h30);
		u_cpu.strobe(1'b0, 1'b0, 8'h03);
		for (int i = 0; i < 3; i++) begin
			{usbWrValid, usbWrData} = {1'b1, buf8[i + 4]};
			@(negedge clk_sys);
			usbWrValid = 1'b0;
			@(negedge clk_sys);
		end
		repeat (2) @(negedge clk_sys);
		check("done count", 8'(doneCount), 8'h01);
		rd(cpu_port_pkg::XFER_COUNT, 8'h00);
		for (int i = 0; i < 3; i++) rd(8'h30 + 8'(i), buf8[i + 4]);
		wr(cpu_port_pkg::BASE_ADDR, 8'h30);
		u_cpu.strobe(1'b0, 1'b0, 8'h02);
		for (int i = 0; i < 2; i++) begin
			usbQ.push_back(buf8[i + 4]);
			usbRdReq = 1'b1;
			@(negedge clk_sys);
			usbRdReq = 1'b0;
			@(negedge clk_sys);
		end
		repeat (5) @(negedge clk_sys);
		check("done count", 8'(doneCount), 8'h02);
		check("notes left", 8'(expQ.size() + usbQ.size()), 8'h00);
		results();
	end
endmodule
